// ==== bench/bidsl_host.sv ====
// host side model: processor issuing io, special io and memory cycles
`default_nettype none
module bidsl_host (
  input wire logic clk,
  output logic io_cycle_active,
  output logic special_io_cycle,
  output logic [20:0] addr,
  output logic rd,
  output logic wr,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    {io_cycle_active, special_io_cycle, rd, wr} = 4'h0;
    addr = 21'h000000;
    data_in = 8'h00;
  end

  // called just after an edge: drive, hold n edges, then release
  task automatic cyc(input logic io, input logic sp, input logic [20:0] a, input logic r, input logic w,
                     input logic [7:0] d, input int n);
    io_cycle_active <= io;
    special_io_cycle <= sp;
    addr <= a;
    rd <= r;
    wr <= w;
    data_in <= d;
    repeat (n) @(posedge clk);
    {io_cycle_active, special_io_cycle, rd, wr} <= 4'h0;
    // released lines float: show the inverse, never the last value
    addr <= ~a;
    data_in <= ~d;
  endtask : cyc
endmodule : bidsl_host
`default_nettype wire

// ==== bench/tb_bidsl_top.sv ====
// self-checking bench for the io decode and status latch block
`default_nettype none
module tb_bidsl_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bidsl_pkg::*;
  localparam int POR = 20; // short power-on count keeps the run brief
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic io_cycle_active, special_io_cycle, rd, wr;
  logic [20:0] addr;
  logic [7:0] data_in;
  logic addr_strobe = 1'b0, cpu_phase = 1'b0, read_ind = 1'b0, mem_write = 1'b0, col_strobe = 1'b0;
  logic video_access = 1'b0, soft_err_in = 1'b0, hard_err_in = 1'b0, retrace_in = 1'b0;
  logic video_invert_opt = 1'b0, video_data = 1'b0, composite_sync = 1'b0, reset_button_in = 1'b1;
  logic [15:0] data_out;
  logic data_oe, boot_rom_sel, xlat_reg_sel, xlat_ram_enable, startup_mode, force_soft_wr, force_hard_wr;
  logic retrace_irq, mem_dir_read, por_out;
  logic quiet = 1'b0; // stops address strobes for the watchdog case
  logic [7:0] range_sel;
  logic [1:0] context_sel;
  logic [5:0] video_page;
  logic [20:0] a;
  logic [15:0] exp_q[$]; // expected read answers, oldest first
  int n_mismatch = 0, n_compared = 0, cyc_n = 0, mb;

  bidsl_top #(.POR_CYCLES(POR)) dut (.clk, .rstn, .io_cycle_active, .special_io_cycle, .addr, .rd, .wr,
    .data_in, .addr_strobe, .cpu_phase, .read_ind, .mem_write, .col_strobe, .video_access, .soft_err_in,
    .hard_err_in, .retrace_in, .video_invert_opt, .video_data, .composite_sync, .reset_button_in, .data_out,
    .data_oe, .range_sel, .boot_rom_sel, .xlat_reg_sel, .xlat_ram_enable, .context_sel, .startup_mode,
    .video_page, .force_soft_wr, .force_hard_wr, .retrace_irq, .mem_dir_read, .por_out);
  bidsl_host host (.clk, .io_cycle_active, .special_io_cycle, .addr, .rd, .wr, .data_in);

  always #50 clk = ~clk;
  // strobe toggles unless quiet, keeping the watchdog fed
  always @(posedge clk) addr_strobe <= !quiet && !addr_strobe;
  // hang guard
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      n_mismatch++;
      test_done();
    end
  end
  // read answers: each data_oe takes the oldest expectation, sampled mid-cycle
  always @(negedge clk) begin
    if (data_oe === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected data_oe", 16'h0000, 16'h0001);
      else check("data_out", exp_q.pop_front(), data_out);
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // an idle edge follows so strobes never re-assert in one step
  task automatic io_wr(input logic [15:0] ofs, input logic [7:0] d);
    host.cyc(1'b1, 1'b0, {5'h01, ofs} | 21'h000200, 1'b0, 1'b1, d, 1);
    @(posedge clk);
  endtask : io_wr
  // only the F000 and F800 blocks answer a read
  task automatic io_rd(input logic [15:0] ofs, input logic [15:0] exp);
    if (ofs[12]) exp_q.push_back(exp);
    host.cyc(1'b1, 1'b0, {5'h01, ofs} | 21'h000200, 1'b1, 1'b0, 8'h00, 1);
    repeat (2) @(posedge clk);
  endtask : io_rd
  task automatic ctl(input int idx, input logic v);
    io_wr(BIDSL_CTRL_OFS | 16'(idx << 1), {7'h00, v});
  endtask : ctl
  // live bits are randomised and held across the read
  task automatic rd_stat(input logic s, input logic hd, input logic b);
    {video_invert_opt, video_data, composite_sync} <= 3'($urandom);
    @(posedge clk);
    io_rd(BIDSL_STATUS_OFS, {9'h000, composite_sync, video_data, ~video_invert_opt, b, 1'b0, hd, s});
  endtask : rd_stat
  task automatic mem_cyc(input logic [20:0] ma, input logic va);
    col_strobe <= 1'b1;
    video_access <= va;
    host.cyc(1'b0, 1'b0, ma, 1'b0, 1'b0, 8'h00, 1);
    col_strobe <= 1'b0;
    @(posedge clk);
  endtask : mem_cyc
  // one-cycle event: 0 soft, 1 hard, 2 retrace
  task automatic pulse(input int k);
    {retrace_in, hard_err_in, soft_err_in} <= 3'(1 << k);
    @(posedge clk);
    {retrace_in, hard_err_in, soft_err_in} <= 3'h0;
    @(posedge clk);
  endtask : pulse

  initial begin
    logic [5:0] v;
    void'($urandom(32'hB638));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("por_out", 16'h0001, {15'h0, por_out});
    check("ctl defaults", 16'h0010, {11'h0, startup_mode, context_sel, force_soft_wr, force_hard_wr});
    for (int i = 0; i < POR + 4 && por_out !== 1'b0; i++) @(posedge clk);
    check("por_end", 16'h0000, {15'h0, por_out});
    for (int r = 0; r < 8; r++) begin
      host.cyc(1'b1, 1'b0, {5'h01, 3'(r), 13'h0200}, 1'b0, 1'b0, 8'h00, 1);
      #1 check("range_sel", 16'(8'h01 << r), {8'h00, range_sel});
      @(posedge clk);
    end
    host.cyc(1'b1, 1'b0, 21'h01E008, 1'b0, 1'b1, 8'h01, 1);
    @(posedge clk);
    host.cyc(1'b1, 1'b0, 21'h00E208, 1'b0, 1'b1, 8'h01, 1);
    @(posedge clk);
    check("ungated write", 16'h0001, {15'h0, startup_mode});
    for (int k = 0; k < 2; k++) begin
      host.cyc(1'b0, 1'b1, 21'(k) << 15, 1'b1, 1'b0, 8'h00, 1);
      #1 check("special sel", k ? 16'h0001 : 16'h0002, {14'h0, boot_rom_sel, xlat_reg_sel});
      @(posedge clk);
    end
    ctl(BIDSL_CB_START, 1'b1);
    ctl(BIDSL_CB_CTXA, 1'b1);
    check("start ctx", 16'h0005, {12'h0, startup_mode, xlat_ram_enable, context_sel});
    ctl(BIDSL_CB_CTXB, 1'b1);
    ctl(BIDSL_CB_CTXA, 1'b0);
    check("ctx", 16'h0002, {14'h0, context_sel});
    v = 6'($urandom);
    io_wr(BIDSL_VPAGE_OFS, {2'b00, v});
    check("video_page", {10'h0, v}, {10'h0, video_page});
    io_rd(BIDSL_CTRL_OFS, 16'h0000);
    // forcing on memory writes
    // the matching flag is unmasked so the forced error shows in the status latch
    for (int k = 0; k < 2; k++) begin
      mb = k ? BIDSL_CB_HMSK : BIDSL_CB_SMSK;
      ctl(mb, 1'b1);
      ctl(k, 1'b0);
      {mem_write, col_strobe} <= 2'b11;
      @(posedge clk);
      {mem_write, col_strobe} <= 2'b00;
      #1 check("force_wr", k ? 16'h0001 : 16'h0002, {14'h0, force_soft_wr, force_hard_wr});
      @(posedge clk);
      ctl(k, 1'b1);
      rd_stat(k == 0, k == 1, 1'b0);
      ctl(mb, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      {cpu_phase, read_ind} <= 2'(k);
      repeat (2) @(posedge clk);
      check("mem_dir_read", 16'(k == 3), {15'h0, mem_dir_read});
    end
    // masks and the error address freeze
    for (int k = 0; k < 2; k++) begin
      mb = k ? BIDSL_CB_HMSK : BIDSL_CB_SMSK;
      pulse(k);
      rd_stat(1'b0, 1'b0, 1'b0);
      ctl(mb, 1'b1);
      a = 21'($urandom);
      v[0] = 1'($urandom);
      mem_cyc(a, v[0]);
      pulse(k);
      mem_cyc(~a, 1'b0);
      io_rd(BIDSL_ERRADDR_OFS, {a[20:6], v[0]});
      rd_stat(k == 0, k == 1, 1'b0);
      ctl(mb, 1'b0);
      rd_stat(1'b0, 1'b0, 1'b0);
      a = ~a;
      mem_cyc(a, 1'b0);
      io_rd(BIDSL_ERRADDR_OFS, {a[20:6], 1'b0});
    end
    quiet <= 1'b1;
    repeat (320) @(posedge clk);
    rd_stat(1'b0, 1'b0, 1'b1);
    quiet <= 1'b0;
    io_rd(BIDSL_ERRADDR_OFS, {a[20:6], 1'b0});
    rd_stat(1'b0, 1'b0, 1'b0);
    pulse(2);
    check("irq masked", 16'h0000, {15'h0, retrace_irq});
    ctl(BIDSL_CB_VMSK, 1'b1);
    pulse(2);
    check("irq", 16'h0001, {15'h0, retrace_irq});
    reset_button_in <= 1'b0;
    repeat (2) @(posedge clk);
    reset_button_in <= 1'b1;
    repeat (2) @(posedge clk);
    check("button por", 16'h0003, {14'h0, por_out, startup_mode});
    for (int i = 0; i < POR + 4 && por_out !== 1'b0; i++) @(posedge clk);
    check("button por_end", 16'h0000, {15'h0, por_out});
    // defaults are back: a soft error stays masked and the retrace flag is gone
    pulse(0);
    rd_stat(1'b0, 1'b0, 1'b0);
    check("reads left", 16'h0000, 16'(exp_q.size()));
    test_done();
  end
endmodule : tb_bidsl_top
`default_nettype wire

// ==== core/bidsl_pkg.sv ====
// package for the board io decode and status latch block
`default_nettype none
package bidsl_pkg;
  // register block bases (16-bit io offsets)
  localparam logic [15:0] BIDSL_CTRL_OFS = 16'hE000;
  localparam logic [15:0] BIDSL_VPAGE_OFS = 16'hE800;
  localparam logic [15:0] BIDSL_ERRADDR_OFS = 16'hF000;
  localparam logic [15:0] BIDSL_STATUS_OFS = 16'hF800;
  // control latch bit positions (index written on addr[3:1])
  localparam int BIDSL_CB_FSOFT = 0;
  localparam int BIDSL_CB_FHARD = 1;
  localparam int BIDSL_CB_CTXA = 2;
  localparam int BIDSL_CB_CTXB = 3;
  localparam int BIDSL_CB_START = 4;
  localparam int BIDSL_CB_SMSK = 5;
  localparam int BIDSL_CB_VMSK = 6;
  localparam int BIDSL_CB_HMSK = 7;
  // control latch reset: active-low diag off, startup mode, all masks on
  localparam logic [7:0] BIDSL_CTRL_RST = 8'h03;
  // status bit positions
  localparam int BIDSL_SB_SOFT = 0;
  localparam int BIDSL_SB_HARD = 1;
  localparam int BIDSL_SB_VRT = 2;
  localparam int BIDSL_SB_BUS_TIMEOUT_FLAG = 3;
  localparam int BIDSL_SB_INV = 4;
  localparam int BIDSL_SB_VID = 5;
  localparam int BIDSL_SB_COMPOSITE_SYNC = 6;
  localparam logic [5:0] BIDSL_VPAGE_RST = 6'h00;
  localparam logic [15:0] BIDSL_ERRADDR_RST = 16'h0000;
  // timing
  localparam int BIDSL_CLK_HZ = 10000000;
  localparam int BIDSL_POR_MS = 1000;
  localparam int BIDSL_POR_CYC = BIDSL_CLK_HZ / 1000 * BIDSL_POR_MS;
  localparam int BIDSL_BUS_TIMEOUT_FLAG_MIN_US = 30;
  localparam int BIDSL_BUS_TIMEOUT_FLAG_MAX_US = 300;
  // timeout set at the short end of the window, 300 cycles
  localparam int BIDSL_BUS_TIMEOUT_FLAG_CYC = (BIDSL_BUS_TIMEOUT_FLAG_MIN_US * (BIDSL_CLK_HZ / 1000000));
  // special io decode of upper address
  typedef enum logic [1:0] {
    BIDSL_SP_ROM = 2'b00,
    BIDSL_SP_XLAT = 2'b01,
    BIDSL_SP_NONE = 2'b11
  } bidsl_sp_t;
endpackage : bidsl_pkg
`default_nettype wire

// ==== core/bidsl_top.sv ====
// io decode, control latch, error address and status latches, time delay logic
`default_nettype none
module bidsl_top #(
  parameter int POR_CYCLES = bidsl_pkg::BIDSL_POR_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic io_cycle_active,
  input wire logic special_io_cycle,
  input wire logic [20:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] data_in,
  input wire logic addr_strobe,
  input wire logic cpu_phase,
  input wire logic read_ind,
  input wire logic mem_write,
  input wire logic col_strobe,
  input wire logic video_access,
  input wire logic soft_err_in,
  input wire logic hard_err_in,
  input wire logic retrace_in,
  input wire logic video_invert_opt,
  input wire logic video_data,
  input wire logic composite_sync,
  input wire logic reset_button_in,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic [7:0] range_sel,
  output logic boot_rom_sel,
  output logic xlat_reg_sel,
  output logic xlat_ram_enable,
  output logic [1:0] context_sel,
  output logic startup_mode,
  output logic [5:0] video_page,
  output logic force_soft_wr,
  output logic force_hard_wr,
  output logic retrace_irq,
  output logic mem_dir_read,
  output logic por_out
);
  import bidsl_pkg::*;

  // control latch; bits 0,1,5,6,7 are active low like the board wiring
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [5:0] vpage_r;
  logic [15:0] eaddr_r;
  logic soft_err_flag, hard_err_flag, retrace_irq_flag, bus_timeout_flag;
  logic [15:0] dout_r;
  logic doe_r;
  logic [7:0] range_r;
  logic rom_r, xlat_r, mdir_r, irq_r;
  logic [31:0] por_cnt_r;
  logic por_r;
  logic [15:0] bto_cnt_r;
  // inverted latch bits kept in flops of their own, so these outputs need no gate
  // they load from ctrl_nxt and therefore change on the same edge as the latch
  logic startup_r, fsoft_r, fhard_r;

  // decode helper: one-hot 3-to-8
  function automatic logic [7:0] bidsl_dec8(input logic [2:0] sel, input logic en);
    bidsl_dec8 = en ? (8'h01 << sel) : 8'h00;
  endfunction : bidsl_dec8

  // first stage enable
  // gated decode
  wire stage1_en = io_cycle_active & addr[9] & addr[16];
  wire [7:0] ranges = bidsl_dec8(addr[15:13], stage1_en);
  // top range enables the board-local second stage
  wire board_io_enable = ranges[7];
  // second stage on a11/a12
  // only the low four codes exist; the upper four stay idle by construction
  wire [7:0] blk8 = bidsl_dec8({1'b0, addr[12:11]}, board_io_enable);
  wire [3:0] blk = blk8[3:0];
  wire ctrl_latch_load = blk[0] & wr;
  wire video_page_load = blk[1] & wr;
  wire err_addr_read_sel = blk[2] & rd;
  wire status_read_sel = blk[3] & rd;

  // the board register decode above is gated by io_cycle_active with a9 and a16, not by special_io_cycle
  // special io decode of a15/a16
  wire [1:0] sp_code = special_io_cycle ? addr[16:15] : BIDSL_SP_NONE;
  wire sp_rom = (sp_code == BIDSL_SP_ROM);
  wire sp_xlat = (sp_code == BIDSL_SP_XLAT);

  // named control bits (masks and diag are active low)
  // the latch resets with diag off, so ordinary writes never fake an error
  wire soft_err_mask = ~ctrl_r[BIDSL_CB_SMSK];
  wire hard_err_mask = ~ctrl_r[BIDSL_CB_HMSK];
  wire retrace_irq_mask = ~ctrl_r[BIDSL_CB_VMSK];
  wire force_soft_err = ~ctrl_r[BIDSL_CB_FSOFT];
  wire force_hard_err = ~ctrl_r[BIDSL_CB_FHARD];

  // addressable latch: addr[3:1] picks the bit, data bit 0 is its value
  // single bit load
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_latch_load) begin
      ctrl_nxt[addr[3:1]] = data_in[0];
    end
  end

  // error sources, with diagnostic forcing during memory writes
  // diag forcing
  wire soft_src = soft_err_in | (force_soft_err & mem_write & col_strobe);
  wire hard_src = hard_err_in | (force_hard_err & mem_write & col_strobe);
  wire any_err = soft_err_flag | hard_err_flag;

  // status latch word: flags shown active high, live bits passed through, video_invert_opt inverted
  // latched flags
  // live bits
  // live bits are not held: a read shows their level at the select edge
  wire [15:0] status_word = {9'h000, composite_sync, video_data, ~video_invert_opt,
                             bus_timeout_flag, retrace_irq_flag, hard_err_flag, soft_err_flag};

  // control latch and video page
  // reset defaults
  // por holds every bit at its default, so software cannot unmask early
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= BIDSL_CTRL_RST;
      startup_r <= ~BIDSL_CTRL_RST[BIDSL_CB_START];
      fsoft_r <= ~BIDSL_CTRL_RST[BIDSL_CB_FSOFT];
      fhard_r <= ~BIDSL_CTRL_RST[BIDSL_CB_FHARD];
    end else if (por_r) begin
      ctrl_r <= BIDSL_CTRL_RST;
      startup_r <= ~BIDSL_CTRL_RST[BIDSL_CB_START];
      fsoft_r <= ~BIDSL_CTRL_RST[BIDSL_CB_FSOFT];
      fhard_r <= ~BIDSL_CTRL_RST[BIDSL_CB_FHARD];
    end else begin
      ctrl_r <= ctrl_nxt;
      startup_r <= ~ctrl_nxt[BIDSL_CB_START];
      fsoft_r <= ~ctrl_nxt[BIDSL_CB_FSOFT];
      fhard_r <= ~ctrl_nxt[BIDSL_CB_FHARD];
    end
  end

  // video page load from a15..a20 field in data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vpage_r <= BIDSL_VPAGE_RST;
    end else if (video_page_load) begin
      vpage_r <= data_in[5:0];
    end
  end

  // error address: tracks every column strobe until an error freezes it
  // reload until error
  // video accesses load a6..a14 too
  // trade-off: video errors still load a6..a14; software must ignore them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eaddr_r <= BIDSL_ERRADDR_RST;
    end else if (col_strobe && !any_err) begin
      eaddr_r <= {addr[20:6], video_access};
    end
  end

  // soft and hard flags: mask low holds the flag clear
  // soft mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_err_flag <= 1'b0;
      hard_err_flag <= 1'b0;
    end else begin
      soft_err_flag <= soft_err_mask ? 1'b0 : (soft_err_flag | soft_src);
      hard_err_flag <= hard_err_mask ? 1'b0 : (hard_err_flag | hard_src);
    end
  end

  // retrace flag and its interrupt; mask keeps both quiet
  // the flag has no clear of its own; only the mask drops it
  // retrace mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      retrace_irq_flag <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      retrace_irq_flag <= retrace_irq_mask ? 1'b0 : (retrace_irq_flag | retrace_in);
      irq_r <= ~retrace_irq_mask & (retrace_irq_flag | retrace_in);
    end
  end

  // bus watchdog; strobe restarts it, a new timeout wins over a read clear
  // timeout detect
  // limitation: the window sits at its short end, so slow slaves trip it early
  wire bto_hit = (bto_cnt_r == 16'(BIDSL_BUS_TIMEOUT_FLAG_CYC - 1));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bto_cnt_r <= 16'h0000;
    end else if (addr_strobe || bto_hit) begin
      bto_cnt_r <= 16'h0000;
    end else begin
      bto_cnt_r <= bto_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_timeout_flag <= 1'b0;
    end else if (bto_hit) begin
      bus_timeout_flag <= 1'b1;
    end else if (err_addr_read_sel) begin
      bus_timeout_flag <= 1'b0;
    end
  end

  // read data mux registered onto the bus
  // data_oe drops the cycle after the select goes away; nothing holds the bus
  // status read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dout_r <= 16'h0000;
      doe_r <= 1'b0;
    end else begin
      dout_r <= status_read_sel ? status_word : (err_addr_read_sel ? eaddr_r : 16'h0000);
      doe_r <= status_read_sel | err_addr_read_sel;
    end
  end

  // decode outputs and direction, registered so outputs come from flops
  // read direction
  // registering costs one cycle on every select, accepted for clean outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      range_r <= 8'h00;
      rom_r <= 1'b0;
      xlat_r <= 1'b0;
      mdir_r <= 1'b0;
    end else begin
      range_r <= ranges;
      rom_r <= sp_rom;
      xlat_r <= sp_xlat;
      mdir_r <= cpu_phase & read_ind;
    end
  end

  // power-on reset timer; button low restarts it, ~1 s at 10 MHz
  // reset stretch
  // the counter is wide enough for the full one second count at this clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt_r <= 32'h00000000;
      por_r <= 1'b1;
    end else if (!reset_button_in) begin
      por_cnt_r <= 32'h00000000;
      por_r <= 1'b1;
    end else if (por_r) begin
      por_cnt_r <= por_cnt_r + 32'h00000001;
      por_r <= (por_cnt_r < 32'(POR_CYCLES - 1));
    end
  end

  // context, start and page outputs straight from latches
  // context feed
  assign context_sel = {ctrl_r[BIDSL_CB_CTXB], ctrl_r[BIDSL_CB_CTXA]};
  assign startup_mode = startup_r;
  assign xlat_ram_enable = ctrl_r[BIDSL_CB_START];
  assign video_page = vpage_r;
  assign force_soft_wr = fsoft_r;
  assign force_hard_wr = fhard_r;
  assign data_out = dout_r;
  assign data_oe = doe_r;
  assign range_sel = range_r;
  assign boot_rom_sel = rom_r;
  assign xlat_reg_sel = xlat_r;
  assign retrace_irq = irq_r;
  assign mem_dir_read = mdir_r;
  assign por_out = por_r;

  // soft flag stays clear while masked
  AST_SOFT_MASK: assert property (@(posedge clk) disable iff (!rstn)
    soft_err_mask |=> !soft_err_flag) else $error("soft flag set while masked");
  AST_HARD_MASK: assert property (@(posedge clk) disable iff (!rstn)
    hard_err_mask |=> !hard_err_flag) else $error("hard flag set while masked");
  AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!rstn)
    retrace_irq_mask |=> !retrace_irq) else $error("retrace irq passed mask");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!rstn)
    any_err |=> $stable(eaddr_r)) else $error("error address moved after error");
  AST_BUS_TIMEOUT_FLAG_CLR: assert property (@(posedge clk) disable iff (!rstn)
    (err_addr_read_sel && !bto_hit) |=> !bus_timeout_flag) else $error("timeout not cleared");
  AST_BUS_TIMEOUT_FLAG_SET: assert property (@(posedge clk) disable iff (!rstn)
    bto_hit |=> bus_timeout_flag) else $error("timeout not flagged");
  AST_STATUS_RD: assert property (@(posedge clk) disable iff (!rstn)
    status_read_sel |=> (data_oe && data_out[3:0] == $past(status_word[3:0]))) else $error("status read wrong");
  AST_MDIR: assert property (@(posedge clk) disable iff (!rstn)
    (cpu_phase && read_ind) |=> mem_dir_read) else $error("read direction missing");
  AST_POR: assert property (@(posedge clk) disable iff (!rstn)
    !reset_button_in |=> por_out [*2]) else $error("reset not stretched");
  // decode, load and reset checks
  // ungated cycles must leave every range select low
  AST_RANGE_OFF: assert property (@(posedge clk) disable iff (!rstn)
    !stage1_en |=> (range_sel == 8'h00)) else $error("range select without gated cycle");
  // error address read answers with the captured word
  AST_ERR_RD: assert property (@(posedge clk) disable iff (!rstn)
    err_addr_read_sel |=> (data_oe && data_out == $past(eaddr_r))) else $error("error address read wrong");
  // page load takes the six data bits
  AST_VPAGE: assert property (@(posedge clk) disable iff (!rstn)
    video_page_load |=> (video_page == $past(data_in[5:0]))) else $error("video page not loaded");
  // boot rom select on special code zero
  AST_ROM_SEL: assert property (@(posedge clk) disable iff (!rstn)
    (special_io_cycle && addr[16:15] == BIDSL_SP_ROM) |=> boot_rom_sel) else $error("boot rom not selected");
  // translation register select on special code one
  AST_XLAT_SEL: assert property (@(posedge clk) disable iff (!rstn)
    (special_io_cycle && addr[16:15] == BIDSL_SP_XLAT) |=> xlat_reg_sel) else $error("xlat regs not selected");
  // an unfrozen column strobe captures a6..a20 and the access kind
  AST_ERR_LOAD: assert property (@(posedge clk) disable iff (!rstn)
    (col_strobe && !any_err) |=> (eaddr_r == {$past(addr[20:6]), $past(video_access)}))
    else $error("error address not captured");
  // power-on reset leaves startup mode on, diag off, masks asserted
  AST_CTRL_POR: assert property (@(posedge clk) disable iff (!rstn)
    por_r |=> (startup_mode && !force_soft_wr && !force_hard_wr && soft_err_mask && hard_err_mask
               && retrace_irq_mask)) else $error("control defaults not restored");
endmodule : bidsl_top
`default_nettype wire
